/* File: src/adc_config_register_bank.sv */
// configuration register bank with clock divider, test patterns and output formatting
`timescale 1ns/1ps
module adc_config_register_bank (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire adc_cfg_pkg::reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire logic [adc_cfg_pkg::NUM_CHAN-1:0][adc_cfg_pkg::SAMPLE_W-1:0] sample_in,
   output logic [adc_cfg_pkg::NUM_CHAN-1:0][adc_cfg_pkg::SAMPLE_W-1:0] sample_out,
   output logic [adc_cfg_pkg::NUM_CHAN-1:0] output_enable,
   output logic output_sample_strobe,
   output logic divided_clock_tick,
   output logic [adc_cfg_pkg::NUM_CHAN-1:0][7:0] offset_trim,
   output adc_cfg_pkg::analog_cfg_t analog_cfg
);
   localparam int NC = adc_cfg_pkg::NUM_CHAN;
   localparam int SW = adc_cfg_pkg::SAMPLE_W;

   logic rst_sync1;
   logic rst_core_n;
   logic [7:0] chan_select;
   logic [7:0] clock_divider_ratio;
   logic [7:0] enhancement_control;
   logic [7:0] fmt_global;
   logic [7:0] output_drive_adjust;
   logic [7:0] clock_phase_control;
   logic [7:0] output_fine_delay;
   logic [7:0] reference_span_select;
   logic [NC-1:0][7:0] test_pattern_select;
   logic [NC-1:0][7:0] fmt_local;
   logic [2:0] div_cnt;
   logic strobe;

   function automatic logic hit(input adc_cfg_pkg::reg_req_t r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   function automatic logic [SW-1:0] encode(input logic [SW-1:0] ob, input logic [1:0] code);
      unique case (code)
         adc_cfg_pkg::FMT_TWOS: encode = ob ^ adc_cfg_pkg::WORD_MSB;
         adc_cfg_pkg::FMT_GRAY: encode = ob ^ (ob >> 1);
         default: encode = ob;
      endcase
   endfunction

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync1 <= 1'b0;
         rst_core_n <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_core_n <= rst_sync1;
      end
   end

   // write decode; writes only take effect while the clock enable is high
   wire wr_chan = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_CHAN_SELECT);
   wire wr_div = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_CLK_DIV);
   wire wr_enh = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_ENH);
   wire wr_test = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_TEST);
   wire wr_offset = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_OFFSET);
   wire wr_fmt = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_OUT_FMT);
   wire wr_drive = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_DRIVE);
   wire wr_phase = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_PHASE);
   wire wr_delay = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_DELAY);
   wire wr_vref = clk_en && hit(reg_req, adc_cfg_pkg::ADDR_VREF);
   wire [7:0] wd = reg_req.wdata;

   // defaults at reset, open bits never stored
   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         chan_select <= adc_cfg_pkg::RST_CHAN_SELECT;
         clock_divider_ratio <= adc_cfg_pkg::RST_ZERO;
         enhancement_control <= adc_cfg_pkg::RST_ZERO;
         fmt_global <= adc_cfg_pkg::RST_ZERO;
         output_drive_adjust <= adc_cfg_pkg::RST_ZERO;
         clock_phase_control <= adc_cfg_pkg::RST_ZERO;
         output_fine_delay <= adc_cfg_pkg::RST_ZERO;
         reference_span_select <= adc_cfg_pkg::RST_VREF;
      end else begin
         if (wr_chan) chan_select <= wd & adc_cfg_pkg::MASK_CHAN_SELECT;
         if (wr_div) clock_divider_ratio <= wd & adc_cfg_pkg::MASK_CLK_DIV;
         if (wr_enh) enhancement_control <= wd & adc_cfg_pkg::MASK_ENH;
         if (wr_fmt) fmt_global <= wd & adc_cfg_pkg::MASK_FMT_GLOBAL;
         if (wr_drive) output_drive_adjust <= wd & adc_cfg_pkg::MASK_DRIVE;
         if (wr_phase) clock_phase_control <= wd & adc_cfg_pkg::MASK_PHASE;
         if (wr_delay) output_fine_delay <= wd & adc_cfg_pkg::MASK_DELAY;
         if (wr_vref) reference_span_select <= wd & adc_cfg_pkg::MASK_VREF;
      end
   end

   // stored analog settings driven straight from the registers
   // chop enable follows bit 2
   assign analog_cfg.chop_enable = enhancement_control[adc_cfg_pkg::CHOP_BIT];
   // drive strength codes held as written
   assign analog_cfg.data_drive = output_drive_adjust[adc_cfg_pkg::DRIVE_DATA_LSB +: 2];
   assign analog_cfg.strobe_drive = output_drive_adjust[adc_cfg_pkg::DRIVE_STROBE_LSB +: 2];
   // separate delay enables, one shared step selector
   assign analog_cfg.data_delay_en = output_fine_delay[adc_cfg_pkg::DATA_DLY_BIT];
   assign analog_cfg.strobe_delay_en = output_fine_delay[adc_cfg_pkg::STROBE_DLY_BIT];
   assign analog_cfg.delay_select = output_fine_delay[adc_cfg_pkg::DELAY_SEL_LSB +: 3];
   assign analog_cfg.reference_select = reference_span_select[adc_cfg_pkg::VREF_LSB +: 3];
   assign analog_cfg.logic_type = fmt_global[adc_cfg_pkg::LOGIC_LSB +: 2];
   assign analog_cfg.interleave = fmt_global[adc_cfg_pkg::INTERLEAVE_BIT];

   // divider: ratio plus one states, tick lands at the phase slot
   wire [2:0] div_ratio = clock_divider_ratio[adc_cfg_pkg::DIV_LSB +: 3];
   wire [2:0] div_phase = clock_phase_control[adc_cfg_pkg::PHASE_LSB +: 3];
   wire [3:0] div_len = {1'b0, div_ratio} + 4'h1;
   wire [3:0] phase_mod = {1'b0, div_phase} % div_len;
   wire div_wrap = div_cnt >= div_ratio;
   wire [2:0] next_div_cnt = div_wrap ? 3'h0 : div_cnt + 3'h1;
   wire tick = clk_en && (div_cnt == phase_mod[2:0]);
   wire next_strobe = tick ^ clock_phase_control[adc_cfg_pkg::STROBE_INV_BIT];

   // counter wraps after ratio plus one cycles
   // phase field shifts the tick slot by whole input cycles
   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         div_cnt <= 3'h0;
         strobe <= 1'b0;
      end else if (clk_en) begin
         div_cnt <= next_div_cnt;
         strobe <= next_strobe;
      end
   end
   assign divided_clock_tick = tick;
   assign output_sample_strobe = strobe;

   // per-channel local state
   genvar ch;
   generate
      for (ch = 0; ch < NC; ch++) begin : g_chan
         logic [22:0] pn_long;
         logic [8:0] pn_short;
         logic alt;
         logic [SW-1:0] dout;
         logic oe;
         logic [7:0] trim;
         // local writes go to every selected channel
         wire sel = chan_select[ch];
         wire [3:0] pat = test_pattern_select[ch][adc_cfg_pkg::PAT_LSB +: 4];
         wire [1:0] fmt = fmt_local[ch][adc_cfg_pkg::FMT_LSB +: 2];
         wire inv = fmt_local[ch][adc_cfg_pkg::INVERT_BIT];
         wire dis = fmt_local[ch][adc_cfg_pkg::PORT_DIS_BIT];
         wire rst_long = wr_test && sel && wd[adc_cfg_pkg::PN_LONG_RST_BIT];
         wire rst_short = wr_test && sel && wd[adc_cfg_pkg::PN_SHORT_RST_BIT];
         wire fb_long = pn_long[22] ^ pn_long[adc_cfg_pkg::PN_LONG_TAP];
         wire fb_short = pn_short[8] ^ pn_short[adc_cfg_pkg::PN_SHORT_TAP];
         logic [SW-1:0] pat_word;
         // pattern words replace conversion data when not off
         always_comb begin
            unique case (pat)
               adc_cfg_pkg::PAT_MIDSCALE: pat_word = adc_cfg_pkg::WORD_MIDSCALE;
               adc_cfg_pkg::PAT_POS_FS: pat_word = adc_cfg_pkg::WORD_ONES;
               adc_cfg_pkg::PAT_NEG_FS: pat_word = adc_cfg_pkg::WORD_ZEROS;
               adc_cfg_pkg::PAT_CHECKER: pat_word = alt ? adc_cfg_pkg::WORD_CHECK_B
                                                        : adc_cfg_pkg::WORD_CHECK_A;
               adc_cfg_pkg::PAT_PN_LONG: pat_word = pn_long[SW-1:0];
               adc_cfg_pkg::PAT_PN_SHORT: pat_word = {pn_short[8], pn_short[8:0]};
               adc_cfg_pkg::PAT_ONE_ZERO: pat_word = alt ? adc_cfg_pkg::WORD_ZEROS
                                                         : adc_cfg_pkg::WORD_ONES;
               default: pat_word = adc_cfg_pkg::WORD_ZEROS;
            endcase
         end
         // format applies to conversion data only, patterns skip the encoding but still take invert
         wire [SW-1:0] coded = (pat == adc_cfg_pkg::PAT_OFF) ? encode(sample_in[ch], fmt)
                                                             : pat_word;
         wire [SW-1:0] next_dout = dis ? adc_cfg_pkg::WORD_ZEROS : (inv ? ~coded : coded);

         // local registers also start from their defaults
         always_ff @(posedge clk_sys or negedge rst_core_n) begin
            if (!rst_core_n) begin
               test_pattern_select[ch] <= adc_cfg_pkg::RST_ZERO;
               trim <= adc_cfg_pkg::RST_ZERO;
               fmt_local[ch] <= adc_cfg_pkg::RST_ZERO;
            end else begin
               if (wr_test && sel) test_pattern_select[ch] <= wd & adc_cfg_pkg::MASK_TEST;
               if (wr_offset && sel) trim <= wd & adc_cfg_pkg::MASK_OFFSET;
               if (wr_fmt && sel) fmt_local[ch] <= wd & adc_cfg_pkg::MASK_FMT_LOCAL;
            end
         end

         // generators advance once per divided sample, reset bit reseeds
         always_ff @(posedge clk_sys or negedge rst_core_n) begin
            if (!rst_core_n) begin
               pn_long <= adc_cfg_pkg::PN_LONG_SEED;
               pn_short <= adc_cfg_pkg::PN_SHORT_SEED;
               alt <= 1'b0;
               dout <= adc_cfg_pkg::WORD_ZEROS;
               oe <= 1'b0;
            end else begin
               if (rst_long) pn_long <= adc_cfg_pkg::PN_LONG_SEED;
               else if (tick) pn_long <= {pn_long[21:0], fb_long};
               if (rst_short) pn_short <= adc_cfg_pkg::PN_SHORT_SEED;
               else if (tick) pn_short <= {pn_short[7:0], fb_short};
               if (tick) begin
                  alt <= ~alt;
                  dout <= next_dout;
                  oe <= ~dis;
               end
            end
         end
         assign sample_out[ch] = dout;
         assign output_enable[ch] = oe;
         assign offset_trim[ch] = trim;
      end
   endgenerate

   // read mux: channel A wins when both are selected
   wire rd_ch = ~chan_select[adc_cfg_pkg::CHAN_A_BIT];
   logic [7:0] rd_word;
   always_comb begin
      unique case (reg_req.addr)
         adc_cfg_pkg::ADDR_CHAN_SELECT: rd_word = chan_select;
         adc_cfg_pkg::ADDR_CLK_DIV: rd_word = clock_divider_ratio;
         adc_cfg_pkg::ADDR_ENH: rd_word = enhancement_control;
         adc_cfg_pkg::ADDR_TEST: rd_word = test_pattern_select[rd_ch];
         adc_cfg_pkg::ADDR_OFFSET: rd_word = offset_trim[rd_ch];
         adc_cfg_pkg::ADDR_OUT_FMT: rd_word = fmt_global | fmt_local[rd_ch];
         adc_cfg_pkg::ADDR_DRIVE: rd_word = output_drive_adjust;
         adc_cfg_pkg::ADDR_PHASE: rd_word = clock_phase_control;
         adc_cfg_pkg::ADDR_DELAY: rd_word = output_fine_delay;
         adc_cfg_pkg::ADDR_VREF: rd_word = reference_span_select;
         default: rd_word = adc_cfg_pkg::RST_ZERO;
      endcase
   end
   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) reg_rdata <= adc_cfg_pkg::RST_ZERO;
      else if (clk_en && reg_req.rd) reg_rdata <= rd_word;
   end

   // implemented bits per address, reads must never show anything outside them
   logic [7:0] rd_mask;
   always_comb begin
      unique case (reg_req.addr)
         adc_cfg_pkg::ADDR_CHAN_SELECT: rd_mask = adc_cfg_pkg::MASK_CHAN_SELECT;
         adc_cfg_pkg::ADDR_CLK_DIV: rd_mask = adc_cfg_pkg::MASK_CLK_DIV;
         adc_cfg_pkg::ADDR_ENH: rd_mask = adc_cfg_pkg::MASK_ENH;
         adc_cfg_pkg::ADDR_TEST: rd_mask = adc_cfg_pkg::MASK_TEST;
         adc_cfg_pkg::ADDR_OFFSET: rd_mask = adc_cfg_pkg::MASK_OFFSET;
         adc_cfg_pkg::ADDR_OUT_FMT: rd_mask = adc_cfg_pkg::MASK_FMT_LOCAL | adc_cfg_pkg::MASK_FMT_GLOBAL;
         adc_cfg_pkg::ADDR_DRIVE: rd_mask = adc_cfg_pkg::MASK_DRIVE;
         adc_cfg_pkg::ADDR_PHASE: rd_mask = adc_cfg_pkg::MASK_PHASE;
         adc_cfg_pkg::ADDR_DELAY: rd_mask = adc_cfg_pkg::MASK_DELAY;
         adc_cfg_pkg::ADDR_VREF: rd_mask = adc_cfg_pkg::MASK_VREF;
         default: rd_mask = adc_cfg_pkg::RST_ZERO;
      endcase
   end

   // helper: cycles between ticks, valid only while timing settings are untouched
   logic [3:0] gap;
   logic quiet;
   always_ff @(posedge clk_sys or negedge rst_core_n) begin
      if (!rst_core_n) begin
         gap <= 4'h0;
         quiet <= 1'b0;
      end else if (clk_en) begin
         gap <= tick ? 4'h1 : gap + 4'h1;
         quiet <= (wr_div || wr_phase) ? 1'b0 : (tick ? 1'b1 : quiet);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_core_n);

   AST_DIV_PERIOD: assert property (tick && quiet && !wr_div |-> gap == div_len)
      else $error("divider period differs from ratio plus one");
   AST_PHASE_SLOT: assert property (tick && div_ratio == 3'h7 |-> div_cnt == div_phase)
      else $error("tick not at programmed phase slot");
   AST_DELAY_FIELDS: assert property (wr_delay |=> analog_cfg.delay_select == $past(wd[2:0])
      && analog_cfg.data_delay_en == $past(wd[5]) && analog_cfg.strobe_delay_en == $past(wd[7]))
      else $error("fine delay settings not taken from write");
   AST_OFFSET_BIN: assert property (tick && g_chan[0].pat == adc_cfg_pkg::PAT_OFF
      && g_chan[0].fmt == adc_cfg_pkg::FMT_OFFSET_BIN && !g_chan[0].inv && !g_chan[0].dis
      |=> sample_out[0] == $past(sample_in[0]))
      else $error("offset binary output differs from sample");
   AST_DRIVE: assert property (wr_drive |=> analog_cfg.data_drive == $past(wd[1:0]))
      else $error("drive strength not held");
   AST_CHOP: assert property (wr_enh |=> analog_cfg.chop_enable == $past(wd[2]))
      else $error("chop enable does not follow bit 2");
   AST_PATTERN: assert property (tick && g_chan[1].pat == adc_cfg_pkg::PAT_POS_FS
      && !g_chan[1].inv && !g_chan[1].dis |=> sample_out[1] == adc_cfg_pkg::WORD_ONES)
      else $error("test pattern did not replace data");
   AST_BOTH_CHAN: assert property (wr_test && chan_select[1:0] == 2'h3
      |=> test_pattern_select[0] == $past(wd) && test_pattern_select[1] == $past(wd))
      else $error("write to both channels missed one");
   AST_OPEN_BITS: assert property (clk_en && reg_req.rd
      |=> (reg_rdata & ~$past(rd_mask)) == 8'h00)
      else $error("open bits read nonzero");
   AST_RESET_VALS: assert property ($rose(rst_core_n) |->
      analog_cfg.reference_select == adc_cfg_pkg::RST_VREF[2:0]
      && chan_select == adc_cfg_pkg::RST_CHAN_SELECT)
      else $error("defaults not loaded at reset");

   COV_BOTH_WRITE: cover property (wr_test && chan_select[1:0] == 2'h3);
   COV_DIV8: cover property (tick && quiet && div_ratio == 3'h7);
   COV_PN_LONG: cover property (tick && g_chan[0].pat == adc_cfg_pkg::PAT_PN_LONG);
   COV_GRAY: cover property (tick && g_chan[1].fmt == adc_cfg_pkg::FMT_GRAY);
   COV_STROBE_INV: cover property (tick && clock_phase_control[adc_cfg_pkg::STROBE_INV_BIT]);
   AST_FROZEN: assert property (!clk_en |=> $stable(div_cnt) && $stable(sample_out)
      && $stable(reference_span_select))
      else $error("state moved while clock enable low");
endmodule

/* File: src/adc_cfg_pkg.sv */
// constants, field layout and carrier types of the converter configuration bank
// Notes on behaviour
// - input clock divided by three-bit ratio field plus one, one to eight.
// - divider phase delayed zero to seven input clock cycles by three-bit field.
// - separate clock and data fine delay enables, shared three-bit step selector.
// - two-bit output format field; code 00 is offset binary.
// - two-bit output drive strength held: 00 single, 01 double, 10 triple.
// - enhancement bit 2 set enables first-stage chopping, clear disables it.
// - channel test pattern other than off replaces conversion data at outputs.
// - local register write lands in every channel whose select bit is set.
package adc_cfg_pkg;
   localparam int NUM_CHAN = 2;
   localparam int SAMPLE_W = 10;

   // register addresses
   localparam logic [7:0] ADDR_CHAN_SELECT = 8'h05;
   localparam logic [7:0] ADDR_CLK_DIV = 8'h0b;
   localparam logic [7:0] ADDR_ENH = 8'h0c;
   localparam logic [7:0] ADDR_TEST = 8'h0d;
   localparam logic [7:0] ADDR_OFFSET = 8'h10;
   localparam logic [7:0] ADDR_OUT_FMT = 8'h14;
   localparam logic [7:0] ADDR_DRIVE = 8'h15;
   localparam logic [7:0] ADDR_PHASE = 8'h16;
   localparam logic [7:0] ADDR_DELAY = 8'h17;
   localparam logic [7:0] ADDR_VREF = 8'h18;

   // implemented bits of each register
   localparam logic [7:0] MASK_CHAN_SELECT = 8'h03;
   localparam logic [7:0] MASK_CLK_DIV = 8'h07;
   localparam logic [7:0] MASK_ENH = 8'h04;
   localparam logic [7:0] MASK_TEST = 8'hff;
   localparam logic [7:0] MASK_OFFSET = 8'hff;
   localparam logic [7:0] MASK_FMT_LOCAL = 8'h17;
   localparam logic [7:0] MASK_FMT_GLOBAL = 8'he0;
   localparam logic [7:0] MASK_DRIVE = 8'h33;
   localparam logic [7:0] MASK_PHASE = 8'h87;
   localparam logic [7:0] MASK_DELAY = 8'ha7;
   localparam logic [7:0] MASK_VREF = 8'h07;

   // reset values
   localparam logic [7:0] RST_CHAN_SELECT = 8'h03;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_VREF = 8'h04;

   // field positions
   localparam int CHAN_A_BIT = 0;
   localparam int CHAN_B_BIT = 1;
   localparam int DIV_LSB = 0;
   localparam int CHOP_BIT = 2;
   localparam int PAT_LSB = 0;
   localparam int PN_SHORT_RST_BIT = 4;
   localparam int PN_LONG_RST_BIT = 5;
   localparam int FMT_LSB = 0;
   localparam int INVERT_BIT = 2;
   localparam int PORT_DIS_BIT = 4;
   localparam int INTERLEAVE_BIT = 5;
   localparam int LOGIC_LSB = 6;
   localparam int DRIVE_DATA_LSB = 0;
   localparam int DRIVE_STROBE_LSB = 4;
   localparam int PHASE_LSB = 0;
   localparam int STROBE_INV_BIT = 7;
   localparam int DELAY_SEL_LSB = 0;
   localparam int DATA_DLY_BIT = 5;
   localparam int STROBE_DLY_BIT = 7;
   localparam int VREF_LSB = 0;

   // output formats
   localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
   localparam logic [1:0] FMT_TWOS = 2'h1;
   localparam logic [1:0] FMT_GRAY = 2'h2;

   // test pattern codes
   localparam logic [3:0] PAT_OFF = 4'h0;
   localparam logic [3:0] PAT_MIDSCALE = 4'h1;
   localparam logic [3:0] PAT_POS_FS = 4'h2;
   localparam logic [3:0] PAT_NEG_FS = 4'h3;
   localparam logic [3:0] PAT_CHECKER = 4'h4;
   localparam logic [3:0] PAT_PN_LONG = 4'h5;
   localparam logic [3:0] PAT_PN_SHORT = 4'h6;
   localparam logic [3:0] PAT_ONE_ZERO = 4'h7;

   // pattern words
   localparam logic [SAMPLE_W-1:0] WORD_MIDSCALE = 10'h200;
   localparam logic [SAMPLE_W-1:0] WORD_ONES = 10'h3ff;
   localparam logic [SAMPLE_W-1:0] WORD_ZEROS = 10'h000;
   localparam logic [SAMPLE_W-1:0] WORD_CHECK_A = 10'h2aa;
   localparam logic [SAMPLE_W-1:0] WORD_CHECK_B = 10'h155;
   localparam logic [SAMPLE_W-1:0] WORD_MSB = 10'h200;

   // pseudo-random generators
   localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
   localparam logic [8:0] PN_SHORT_SEED = 9'h1ff;
   localparam int PN_LONG_TAP = 17;
   localparam int PN_SHORT_TAP = 4;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [1:0] logic_type;
      logic interleave;
      logic chop_enable;
      logic [1:0] data_drive;
      logic [1:0] strobe_drive;
      logic data_delay_en;
      logic strobe_delay_en;
      logic [2:0] delay_select;
      logic [2:0] reference_select;
   } analog_cfg_t;
endpackage

/* File: bench/cfg_host_model.sv */
// host controller model driving the configuration register port
`timescale 1ns/1ps
module cfg_host_model (
   input wire logic clk_sys,
   output adc_cfg_pkg::reg_req_t reg_req,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_req = '0;
   end

   // host write cycle
   // idle address and data show the inverse, never the stale value
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      // let the write land before callers look at the outputs
      #1;
   endtask

   // read strobe for one cycle, data taken once the edge has landed
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys);
      reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
      #1;
      v = reg_rdata;
   endtask
endmodule

/* File: bench/tb.sv */
// self-checking bench for the converter configuration bank
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [adc_cfg_pkg::NUM_CHAN-1:0][adc_cfg_pkg::SAMPLE_W-1:0] sample_in = '0;
   logic [adc_cfg_pkg::NUM_CHAN-1:0][adc_cfg_pkg::SAMPLE_W-1:0] sample_out;
   logic [adc_cfg_pkg::NUM_CHAN-1:0][7:0] offset_trim;
   logic [adc_cfg_pkg::NUM_CHAN-1:0] output_enable;
   logic [7:0] reg_rdata;
   logic output_sample_strobe;
   logic divided_clock_tick;
   adc_cfg_pkg::reg_req_t reg_req;
   adc_cfg_pkg::analog_cfg_t analog_cfg;
   int fails = 0;
   int checks = 0;
   int cyc = 0;

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   adc_config_register_bank adc_config_register_bank_i (.clk_sys(clk_sys), .rst_n(rst_n),
      .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_in(sample_in),
      .sample_out(sample_out), .output_enable(output_enable),
      .output_sample_strobe(output_sample_strobe), .divided_clock_tick(divided_clock_tick),
      .offset_trim(offset_trim), .analog_cfg(analog_cfg));
   cfg_host_model cfg_host_model_i (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, the whole run needs a few hundred cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      cfg_host_model_i.rd_reg(a, v);
      chk(v, e);
   endtask

   // cycles until the next divider tick, bounded
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (divided_clock_tick !== 1'b1 && n < 20);
   endtask

   // expected encoding of an offset binary sample
   function automatic logic [9:0] enc(input logic [9:0] x, input logic [1:0] f);
      case (f)
         2'h1: enc = x ^ 10'h200;
         2'h2: enc = x ^ (x >> 1);
         default: enc = x;
      endcase
   endfunction

   task automatic t_reset;
      logic [7:0] ad [0:10];
      logic [7:0] ex [0:10];
      ad = '{8'h05, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h13};
      ex = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
      for (int i = 0; i < 11; i++) begin
         rd_chk(ad[i], ex[i]);
      end
      chk(analog_cfg.reference_select, 3'h4);
      $display("test reset done");
   endtask

   task automatic t_regs;
      cfg_host_model_i.wr_reg(8'h0c, 8'h04);
      rd_chk(8'h0c, 8'h04);
      chk(analog_cfg.chop_enable, 1'b1);
      cfg_host_model_i.wr_reg(8'h0c, 8'h00);
      chk(analog_cfg.chop_enable, 1'b0);
      cfg_host_model_i.wr_reg(8'h15, 8'h12);
      chk({analog_cfg.data_drive, analog_cfg.strobe_drive}, 4'h9);
      cfg_host_model_i.wr_reg(8'h17, 8'ha5);
      chk({analog_cfg.strobe_delay_en, analog_cfg.data_delay_en}, 2'h3);
      chk(analog_cfg.delay_select, 3'h5);
      cfg_host_model_i.wr_reg(8'h17, 8'h20);
      chk({analog_cfg.strobe_delay_en, analog_cfg.data_delay_en}, 2'h1);
      cfg_host_model_i.wr_reg(8'h18, 8'h02);
      rd_chk(8'h18, 8'h02);
      // a write while the clock enable is low must be lost
      @(posedge clk_sys);
      clk_en <= 1'b0;
      cfg_host_model_i.wr_reg(8'h18, 8'h05);
      clk_en <= 1'b1;
      rd_chk(8'h18, 8'h02);
      $display("test registers done");
   endtask

   task automatic t_div;
      int n;
      for (int r = 0; r < 8; r++) begin
         cfg_host_model_i.wr_reg(8'h0b, r[7:0]);
         wait_tick(n);
         wait_tick(n);
         chk(n, r + 1);
      end
      $display("test divider done");
   endtask

   task automatic t_phase;
      int n;
      time t0;
      for (int p = 1; p < 8; p++) begin
         cfg_host_model_i.wr_reg(8'h16, 8'h00);
         wait_tick(n);
         t0 = $time;
         cfg_host_model_i.wr_reg(8'h16, p[7:0]);
         wait_tick(n);
         chk(int'(($time - t0) / 10) % 8, p);
      end
      cfg_host_model_i.wr_reg(8'h16, 8'h00);
      wait_tick(n);
      @(negedge clk_sys);
      chk(output_sample_strobe, 1'b1);
      cfg_host_model_i.wr_reg(8'h16, 8'h80);
      wait_tick(n);
      @(negedge clk_sys);
      chk(output_sample_strobe, 1'b0);
      cfg_host_model_i.wr_reg(8'h16, 8'h00);
      $display("test phase done");
   endtask

   task automatic t_fmt;
      logic [9:0] w [0:3];
      logic [9:0] prev;
      w = '{10'h2c5, 10'h200, 10'h3ff, 10'h000};
      cfg_host_model_i.wr_reg(8'h0b, 8'h00);
      @(posedge clk_sys);
      sample_in <= {10'h0c3, 10'h2c5};
      for (int f = 0; f < 3; f++) begin
         cfg_host_model_i.wr_reg(8'h14, f[7:0]);
         repeat (3) @(negedge clk_sys);
         chk(sample_out[0], enc(10'h2c5, f[1:0]));
         chk(sample_out[1], enc(10'h0c3, f[1:0]));
      end
      cfg_host_model_i.wr_reg(8'h14, 8'h00);
      // alternating checkerboard, then long generator right after its reseed
      cfg_host_model_i.wr_reg(8'h0d, 8'h04);
      repeat (2) @(negedge clk_sys);
      prev = sample_out[0];
      @(negedge clk_sys);
      chk(sample_out[0] ^ prev, 10'h3ff);
      chk(prev == 10'h2aa || prev == 10'h155, 1'b1);
      cfg_host_model_i.wr_reg(8'h0d, 8'h25);
      repeat (2) @(negedge clk_sys);
      chk(sample_out[0], 10'h3ff);
      @(negedge clk_sys);
      chk(sample_out[0], 10'h3fe);
      for (int c = 3; c >= 0; c--) begin
         cfg_host_model_i.wr_reg(8'h0d, c[7:0]);
         repeat (3) @(negedge clk_sys);
         chk(sample_out[0], w[c]);
      end
      $display("test format done");
   endtask

   task automatic t_chan;
      cfg_host_model_i.wr_reg(8'h05, 8'h01);
      cfg_host_model_i.wr_reg(8'h0d, 8'h02);
      repeat (3) @(negedge clk_sys);
      chk(sample_out, {10'h0c3, 10'h3ff});
      cfg_host_model_i.wr_reg(8'h05, 8'h03);
      cfg_host_model_i.wr_reg(8'h0d, 8'h03);
      repeat (3) @(negedge clk_sys);
      chk(sample_out, 20'h00000);
      cfg_host_model_i.wr_reg(8'h10, 8'h5a);
      chk(offset_trim, 16'h5a5a);
      cfg_host_model_i.wr_reg(8'h05, 8'h02);
      cfg_host_model_i.wr_reg(8'h10, 8'h11);
      cfg_host_model_i.wr_reg(8'h05, 8'h03);
      chk(offset_trim, 16'h115a);
      rd_chk(8'h10, 8'h5a);
      cfg_host_model_i.wr_reg(8'h0d, 8'h00);
      // port disable lands on channel b only
      cfg_host_model_i.wr_reg(8'h05, 8'h02);
      cfg_host_model_i.wr_reg(8'h14, 8'h10);
      repeat (3) @(negedge clk_sys);
      chk(output_enable, 2'h1);
      chk(sample_out[1], 10'h000);
      cfg_host_model_i.wr_reg(8'h14, 8'h00);
      cfg_host_model_i.wr_reg(8'h05, 8'h03);
      repeat (3) @(negedge clk_sys);
      chk(output_enable, 2'h3);
      $display("test channels done");
   endtask

   // reset held sixteen cycles, first request well after release
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_reset();
      t_regs();
      t_div();
      t_phase();
      t_fmt();
      t_chan();
      conclude();
   end
endmodule
